// ==== crc_cal_if.sv ====
// crc_cal_if: write and load paths between the command decoder and one
// channel's calibration register pair.
// assumes: all signals sit in the ref_clk domain.
`timescale 1ns/1ps
interface crc_cal_if;
  logic wr_gain; // write strobe for the gain word
  logic wr_off; // write strobe for the offset word
  logic [15:0] wdata; // raw written word
  logic load; // take stored user values
  logic [15:0] load_gain; // stored gain word
  logic [15:0] load_off; // stored offset word
  logic [15:0] gain; // held gain word, fixed bits applied
  logic [15:0] off; // held offset word, fixed bits applied
  // decoder side
  modport ctrl (
    output wr_gain, wr_off, wdata, load, load_gain, load_off,
    input gain, off
  );
  // register side
  modport regs (
    input wr_gain, wr_off, wdata, load, load_gain, load_off,
    output gain, off
  );
endinterface

// ==== crc_cal_regs.sv ====
// crc_cal_regs: paged current sense calibration registers of a dual
// channel regulator, with offset correction of the measured current.
// assumes: a serial bus front end hands over decoded commands with the
// current page; measured currents arrive in 62.5 mA steps, signed.
`timescale 1ns/1ps

module crc_cal_regs
  import crc_pkg::*;
#(
  parameter int CUR_W = 16 // width of measured current words
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [7:0] page,
  input wire logic ch2_is_slave,
  input wire logic user_valid,
  input wire logic restore_user,
  input wire logic [crc_pkg::NCH*16-1:0] user_gain,
  input wire logic [crc_pkg::NCH*16-1:0] user_offset,
  input wire logic alert_clear,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] meas_current,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] warn_limit,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] fault_limit,
  output logic resp_valid,
  output logic resp_ack,
  output logic [15:0] resp_rdata,
  output logic invalid_command_fault,
  output logic smb_alert_o,
  output logic smb_alert_oe_b,
  output logic [crc_pkg::NCH*16-1:0] gain_eff,
  output logic [crc_pkg::NCH*16-1:0] offset_eff,
  output logic [crc_pkg::NCH*CUR_W-1:0] output_current_readback,
  output logic [crc_pkg::NCH-1:0] oc_warning,
  output logic [crc_pkg::NCH-1:0] oc_fault
);
  import crc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_m_q; // first stage, read only by the second
  logic rst_n_q; // synchronised reset used by everything else

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  crc_page_e page_sel; // channel selection from page bits 7 and 0
  logic is_gain; // command addresses the gain word
  logic is_off; // command addresses the offset word
  logic is_cal; // command addresses either word
  logic page_ok; // page code is one of the three legal ones
  logic wr_reject; // write to channel two while it is a slave
  logic wr_go; // accepted write
  logic wr_ch1; // write lands on channel one
  logic wr_ch2; // write lands on channel two
  logic load_now; // take stored user values this cycle
  logic boot_q; // first cycle after reset release

  assign page_sel = crc_page_e'({page[PAGE_HI_BIT], page[PAGE_LO_BIT]});
  assign is_gain = (cmd_code == CMD_GAIN);
  assign is_off = (cmd_code == CMD_OFFSET);
  assign is_cal = is_gain | is_off;
  assign page_ok = (page_sel != CRC_PG_RSVD);

  // page 1 writes only while channel two is a master
  assign wr_reject = cmd_valid & cmd_write & is_cal & ch2_is_slave
                     & (page_sel == CRC_PG_CH2);
  assign wr_go = cmd_valid & cmd_write & is_cal & page_ok & ~wr_reject;

  // a both-page write always lands on channel one and skips a slave channel two
  always_comb
  begin
    wr_ch1 = 1'b0;
    wr_ch2 = 1'b0;
    unique case (page_sel)
      CRC_PG_CH1:
        wr_ch1 = wr_go;
      CRC_PG_CH2:
        wr_ch2 = wr_go;
      CRC_PG_BOTH:
      begin
        wr_ch1 = wr_go;
        wr_ch2 = wr_go & ~ch2_is_slave;
      end
      CRC_PG_RSVD:
      begin
        wr_ch1 = 1'b0;
        wr_ch2 = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // while user_valid is high, stored settings are taken once after reset and on each restore
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  assign load_now = user_valid & (boot_q | restore_user);

  ////////////////////////////////////////////////////////////////////////
  // per channel register pairs and current correction
  crc_cal_if cal [NCH] ();
  logic [15:0] gain_sel [NCH]; // effective gain per channel
  logic [15:0] off_sel [NCH]; // effective offset per channel

  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
      logic signed [CUR_W-1:0] meas; // raw measured current
      logic signed [CUR_W-1:0] ofs; // offset in current steps
      logic signed [CUR_W-1:0] corr; // corrected current
      logic [CUR_W-1:0] corr_q; // registered readback
      logic warn_q; // warning compare result
      logic fault_q; // fault compare result

      // write and load strobes for this channel
      assign cal[c].wr_gain = (c == 0 ? wr_ch1 : wr_ch2) & is_gain;
      assign cal[c].wr_off = (c == 0 ? wr_ch1 : wr_ch2) & is_off;
      assign cal[c].wdata = cmd_wdata;
      assign cal[c].load = load_now;
      assign cal[c].load_gain = user_gain[c*WORD_W +: WORD_W];
      assign cal[c].load_off = user_offset[c*WORD_W +: WORD_W];

      crc_chan_regs u_regs (
        .clk (ref_clk),
        .rst_n (rst_n_q),
        .cal (cal[c])
      );

      // a slave channel two runs on channel one's values
      assign gain_sel[c] = (c != 0 && ch2_is_slave) ? cal[0].gain : cal[c].gain;
      assign off_sel[c] = (c != 0 && ch2_is_slave) ? cal[0].off : cal[c].off;
      assign gain_eff[c*WORD_W +: WORD_W] = gain_sel[c];
      assign offset_eff[c*WORD_W +: WORD_W] = off_sel[c];

      // offset mantissa sign extended to the current width
      assign meas = meas_current[c*CUR_W +: CUR_W];
      assign ofs = CUR_W'($signed(off_sel[c][MAN_W-1:0]));
      assign corr = meas + ofs;

      // readback and both overcurrent compares see the corrected value
      always_ff @(posedge ref_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          corr_q <= '0;
          warn_q <= 1'b0;
          fault_q <= 1'b0;
        end
        else
        begin
          corr_q <= corr;
          warn_q <= (corr >= $signed(warn_limit[c*CUR_W +: CUR_W]));
          fault_q <= (corr >= $signed(fault_limit[c*CUR_W +: CUR_W]));
        end
      end

      assign output_current_readback[c*CUR_W +: CUR_W] = corr_q;
      assign oc_warning[c] = warn_q;
      assign oc_fault[c] = fault_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data: page 1 returns what channel two really uses
  logic [15:0] rd_word; // word chosen for a read

  always_comb
  begin
    rd_word = 16'h0000;
    if (page_sel == CRC_PG_CH2)
      rd_word = is_gain ? gain_sel[1] : off_sel[1];
    else
      rd_word = is_gain ? gain_sel[0] : off_sel[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // answer one cycle after each gain or offset command
  logic resp_valid_q; // answer strobe
  logic resp_ack_q; // ack or nack
  logic [15:0] resp_rdata_q; // read data

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      resp_valid_q <= 1'b0;
      resp_ack_q <= 1'b0;
    end
    else
    begin
      resp_valid_q <= cmd_valid & is_cal;
      // rejected slave writes and unknown pages are not acknowledged
      resp_ack_q <= cmd_valid & is_cal & page_ok & ~wr_reject;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      resp_rdata_q <= 16'h0000;
    else if (cmd_valid & is_cal & ~cmd_write & page_ok)
      resp_rdata_q <= rd_word;
  end

  assign resp_valid = resp_valid_q;
  assign resp_ack = resp_ack_q;
  assign resp_rdata = resp_rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // invalid command fault, sticky; a new reject wins over a clear
  logic cmd_fault_q; // fault flag, also drives the alert line

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cmd_fault_q <= 1'b0;
    else if (wr_reject)
      cmd_fault_q <= 1'b1;
    else if (alert_clear)
      cmd_fault_q <= 1'b0;
  end

  assign invalid_command_fault = cmd_fault_q;
  // open drain alert: pulls low while the fault stands
  assign smb_alert_o = 1'b0;
  assign smb_alert_oe_b = ~cmd_fault_q;

endmodule

// ==== crc_cal_regs_checker.sv ====
// crc_cal_regs_checker: port level timing and field checks of the calibration block.
// assumes: bound into crc_cal_regs, all in the ref_clk domain.
`timescale 1ns/1ps
module crc_cal_regs_checker
  import crc_pkg::*;
#(
  parameter int CUR_W = 16
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] page,
  input wire logic ch2_is_slave,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic invalid_command_fault,
  input wire logic smb_alert_oe_b,
  input wire logic [crc_pkg::NCH*16-1:0] gain_eff,
  input wire logic [crc_pkg::NCH*16-1:0] offset_eff,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] meas_current,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] fault_limit,
  input wire logic [crc_pkg::NCH*CUR_W-1:0] output_current_readback,
  input wire logic [crc_pkg::NCH-1:0] oc_fault
);
  logic [2:0] up_q; // edges since release, saturating
  logic hit; // calibration command this cycle
  logic [CUR_W-1:0] off1_w; // channel one offset, sign extended
  logic [CUR_W-1:0] meas1_w; // channel one measured current
  logic [CUR_W-1:0] lim1_w; // channel one fault limit
  // checks wait until the synchronised reset has let go
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      up_q <= 3'h0;
    else if (up_q != 3'h5)
      up_q <= up_q + 3'h1;
  end
  assign hit = cmd_valid && (cmd_code == CMD_GAIN || cmd_code == CMD_OFFSET);
  assign off1_w = CUR_W'($signed(offset_eff[10:0]));
  assign meas1_w = meas_current[CUR_W-1:0];
  assign lim1_w = fault_limit[CUR_W-1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (up_q != 3'h5);
  ////////////////////////////////////////////////////////////////////////////////
  a_page0_acked: assert property (
    hit && cmd_write && page[7] == 1'b0 && page[0] == 1'b0 |=> resp_valid && resp_ack)
    else $error("page zero write not acked next cycle");
  a_no_stray: assert property (
    !hit |=> !resp_valid)
    else $error("answer without a command");
  a_slave_reject: assert property (
    hit && cmd_write && page[7] == 1'b0 && page[0] && ch2_is_slave
    |=> resp_valid && !resp_ack && invalid_command_fault && !smb_alert_oe_b)
    else $error("slave page write not refused");
  a_gain_exp: assert property (
    gain_eff[15:11] == GAIN_EXP && gain_eff[31:27] == GAIN_EXP)
    else $error("gain exponent not fixed");
  a_gain_span: assert property (
    $signed(gain_eff[10:0]) >= 16 && $signed(gain_eff[10:0]) <= 508
    && $signed(gain_eff[26:16]) >= 16 && $signed(gain_eff[26:16]) <= 508)
    else $error("gain mantissa out of span");
  a_off_fixed: assert property (
    offset_eff[15:11] == OFF_EXP && offset_eff[9:6] == {4{offset_eff[10]}})
    else $error("offset fixed bits wrong");
  a_slave_mirror: assert property (
    ch2_is_slave [*2] |-> gain_eff[31:16] == gain_eff[15:0]
    && offset_eff[31:16] == offset_eff[15:0])
    else $error("slave channel not mirroring");
  a_readback_sum: assert property (
    ##1 output_current_readback[CUR_W-1:0] == $past(meas1_w) + $past(off1_w))
    else $error("readback not offset corrected");
  a_fault_cmp: assert property (
    ##1 oc_fault[0]
    == ($signed(output_current_readback[CUR_W-1:0]) >= $signed($past(lim1_w))))
    else $error("fault compare wrong");
endmodule
bind crc_cal_regs crc_cal_regs_checker #(.CUR_W(CUR_W)) chk (.ref_clk, .rst_b, .cmd_valid,
  .cmd_write, .cmd_code, .page, .ch2_is_slave, .resp_valid, .resp_ack,
  .invalid_command_fault, .smb_alert_oe_b, .gain_eff, .offset_eff, .meas_current,
  .fault_limit, .output_current_readback, .oc_fault);

// ==== crc_chan_regs.sv ====
// crc_chan_regs: one channel's gain and offset calibration words.
// assumes: synchronous strobes from the decoder, reset already synchronised.
`timescale 1ns/1ps
module crc_chan_regs
  import crc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  crc_cal_if.regs cal
);

  logic [15:0] gain_q; // held gain word
  logic [15:0] off_q; // held offset word

  ////////////////////////////////////////////////////////////////////////
  // gain word: stored values win over a write in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gain_q <= {GAIN_EXP, GAIN_MAN_RST};
    else if (cal.load)
      gain_q <= crc_fix_gain(cal.load_gain);
    else if (cal.wr_gain)
      // exponent bits dropped, mantissa kept in span
      gain_q <= crc_fix_gain(cal.wdata);
  end

  ////////////////////////////////////////////////////////////////////////
  // offset word: out of range values alias through the fixed bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      off_q <= {OFF_EXP, OFF_MAN_RST};
    else if (cal.load)
      off_q <= crc_fix_offset(cal.load_off);
    else if (cal.wr_off)
      off_q <= crc_fix_offset(cal.wdata);
  end

  // held words back to the decoder
  assign cal.gain = gain_q;
  assign cal.off = off_q;

endmodule

// ==== crc_host.sv ====
// crc_host: host controller model driving the command port one word at a time.
// assumes: the answer stands in the cycle after the taking edge.
`timescale 1ns/1ps
module crc_host
(
  input wire logic ref_clk,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic [15:0] resp_rdata,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic [7:0] page
);
  // idle port, data line shows no real word
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'hA5A5;
    page = 8'h00;
  end
  // one command: raise after an edge, hold over the taking edge, take the answer
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d,
    input logic [7:0] pg, output logic ack, output logic [15:0] rd);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = code;
    cmd_wdata = d;
    page = pg;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~d;
    ack = resp_valid ? resp_ack : 1'bx;
    rd = resp_rdata;
  endtask
  // host leaves both channels at the nominal half milliohm gain
  task automatic keep_nominal();
    logic a;
    logic [15:0] r;
    xfer(1'b1, 8'h38, 16'h0020, 8'h81, a, r);
  endtask
endmodule

// ==== crc_pkg.sv ====
// crc_pkg: command codes, field layout, fixed bits and helpers for the
// current sense calibration registers.
// assumes: linear format words of 16 bits, two channels.
package crc_pkg;
  // command codes of the two calibration registers
  localparam logic [7:0] CMD_GAIN = 8'h38;
  localparam logic [7:0] CMD_OFFSET = 8'h39;
  // linear format layout: exponent on top, mantissa below
  localparam int EXP_LSB = 11;
  localparam int MAN_W = 11;
  localparam int WORD_W = 16;
  localparam int NCH = 2;
  // fixed exponents: -16 for gain, -4 for offset
  localparam logic [4:0] GAIN_EXP = 5'h10;
  localparam logic [4:0] OFF_EXP = 5'h1C;
  // gain mantissa default and legal span
  localparam logic [10:0] GAIN_MAN_RST = 11'h020;
  localparam logic [10:0] GAIN_MAN_MIN = 11'h010;
  localparam logic [10:0] GAIN_MAN_MAX = 11'h1FC;
  // offset mantissa default, sign bit and writable low bits
  localparam logic [10:0] OFF_MAN_RST = 11'h000;
  localparam int OFF_SIGN_BIT = 10;
  localparam int OFF_FREE_W = 6;
  localparam int OFF_EXT_W = 4;
  // page bits that pick the channel
  localparam int PAGE_HI_BIT = 7;
  localparam int PAGE_LO_BIT = 0;
  // page selection codes
  typedef enum logic [1:0] {
    CRC_PG_CH1 = 2'h0,
    CRC_PG_CH2 = 2'h1,
    CRC_PG_RSVD = 2'h2,
    CRC_PG_BOTH = 2'h3
  } crc_page_e;

  // force gain exponent, clamp mantissa into its span
  function automatic logic [15:0] crc_fix_gain(input logic [15:0] w);
    logic signed [10:0] m;
    m = w[MAN_W-1:0];
    if (m < $signed(GAIN_MAN_MIN))
      m = GAIN_MAN_MIN;
    else if (m > $signed(GAIN_MAN_MAX))
      m = GAIN_MAN_MAX;
    return {GAIN_EXP, m};
  endfunction

  // force offset exponent, copy sign over the four bits below it
  function automatic logic [15:0] crc_fix_offset(input logic [15:0] w);
    logic s;
    s = w[OFF_SIGN_BIT];
    return {OFF_EXP, s, {OFF_EXT_W{s}}, w[OFF_FREE_W-1:0]};
  endfunction
endpackage

// ==== testbench.sv ====
// testbench: command sequences against the calibration register block.
// assumes: crc_host owns the command port; ref_clk at 50 MHz.
`timescale 1ns/1ps
module testbench;
  import crc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ch2_is_slave = 1'b0;
  logic user_valid = 1'b0;
  logic restore_user = 1'b0;
  logic alert_clear = 1'b0;
  logic [31:0] user_gain = 32'h0100_0040;
  logic [31:0] user_offset = 32'h0000_0041;
  logic [31:0] meas_current = 32'h0000_0000;
  logic [31:0] warn_limit = 32'h7FFF_7FFF;
  logic [31:0] fault_limit = 32'h7FFF_7FFF;
  logic cmd_valid, cmd_write, resp_valid, resp_ack, ack;
  logic invalid_command_fault, smb_alert_o, smb_alert_oe_b;
  logic [7:0] cmd_code, page;
  logic [15:0] cmd_wdata, resp_rdata, rd;
  logic [31:0] gain_eff, offset_eff, output_current_readback;
  logic [1:0] oc_warning, oc_fault;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // gain and offset write values with their held results
  logic [15:0] gin[4] = '{16'h7FFF, 16'h01FD, 16'h01FC, 16'h0010};
  logic [15:0] gex[4] = '{16'h8010, 16'h81FC, 16'h81FC, 16'h8010};
  logic [15:0] oin[3] = '{16'hE401, 16'h003F, 16'h0400};
  logic [15:0] oex[3] = '{16'hE7C1, 16'hE03F, 16'hE7C0};
  always #10 ref_clk = ~ref_clk;
  crc_cal_regs dut (.ref_clk, .rst_b, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .page,
    .ch2_is_slave, .user_valid, .restore_user, .user_gain, .user_offset, .alert_clear,
    .meas_current, .warn_limit, .fault_limit, .resp_valid, .resp_ack, .resp_rdata,
    .invalid_command_fault, .smb_alert_o, .smb_alert_oe_b, .gain_eff, .offset_eff,
    .output_current_readback, .oc_warning, .oc_fault);
  crc_host host (.ref_clk, .resp_valid, .resp_ack, .resp_rdata, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .page);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [7:0] pg,
    input logic ea);
    host.xfer(1'b1, c, d, pg, ack, rd);
    chk(ack, ea);
  endtask
  task automatic rdw(input logic [7:0] c, input logic [7:0] pg);
    host.xfer(1'b0, c, 16'h0000, pg, ack, rd);
    chk(ack, 1'b1);
  endtask
  // one cycle strobe: 1 reloads stored settings, 0 clears the fault flag
  task automatic pulse(input logic sel);
    if (sel)
      restore_user = 1'b1;
    else
      alert_clear = 1'b1;
    @(posedge ref_clk);
    #1;
    restore_user = 1'b0;
    alert_clear = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done();
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      test_done();
    end
  end
  initial
  begin
    do_reset();
    rdw(CMD_GAIN, 8'h00);
    chk(rd, 16'h8020);
    rdw(CMD_OFFSET, 8'h00);
    chk(rd, 16'hE000);
    for (int i = 0; i < 4; i++)
    begin
      wr(CMD_GAIN, gin[i], 8'h00, 1'b1);
      chk(gain_eff[15:0], gex[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(CMD_OFFSET, oin[i], 8'h81, 1'b1);
      chk(offset_eff, {oex[i], oex[i]});
    end
    rdw(CMD_OFFSET, 8'h01);
    chk(rd, 16'hE7C0);
    wr(CMD_GAIN, 16'h0050, 8'h80, 1'b0);
    chk(invalid_command_fault, 1'b0);
    wr(CMD_GAIN, 16'h0100, 8'h01, 1'b1);
    chk(gain_eff, 32'h8100_8010);
    ch2_is_slave = 1'b1;
    wr(CMD_GAIN, 16'h0030, 8'h01, 1'b0);
    chk({smb_alert_o, invalid_command_fault, smb_alert_oe_b}, 3'b010);
    wr(CMD_GAIN, 16'h0040, 8'h00, 1'b1);
    chk(gain_eff, 32'h8040_8040);
    pulse(1'b0);
    chk({smb_alert_o, invalid_command_fault, smb_alert_oe_b}, 3'b001);
    // both-page write while slave lands on channel one only, no fault
    wr(CMD_GAIN, 16'h0060, 8'h81, 1'b1);
    chk({invalid_command_fault, gain_eff}, {1'b0, 32'h8060_8060});
    ch2_is_slave = 1'b0;
    meas_current = 32'hFFF0_0064;
    fault_limit = 32'hFFB1_0024;
    warn_limit = 32'hFF00_7FFF;
    repeat (2) @(posedge ref_clk);
    #1;
    // channel two kept its own word through the refused and both-page writes
    chk(gain_eff, 32'h8100_8060);
    chk(output_current_readback, 32'hFFB0_0024);
    chk({oc_warning, oc_fault}, 4'b1001);
    user_valid = 1'b1;
    do_reset();
    chk({gain_eff, offset_eff}, 64'h8100_8040_E000_E001);
    wr(CMD_GAIN, 16'h0020, 8'h00, 1'b1);
    pulse(1'b1);
    chk(gain_eff[15:0], 16'h8040);
    host.keep_nominal();
    chk(gain_eff, 32'h8020_8020);
    test_done();
  end
endmodule
